// >>> hw/cbiu_cfg.svh
// constants for the cache and bus interface unit
`ifndef CBIU_CFG_SVH
`define CBIU_CFG_SVH
`define CBIU_IC_LINES 256
`define CBIU_IC_WORDS 1024
`define CBIU_DC_LINES 256
`define CBIU_WB_DEPTH 4
`define CBIU_RB_DEPTH 4
`define CBIU_QUAD_WORDS 3'h4
`define CBIU_LINE_LSB 4
`define CBIU_WORD_LSB 2
`define CBIU_MODE_HALF 2'h1
`define CBIU_MODE_QUARTER 2'h2
`define CBIU_PORT_8 2'h0
`define CBIU_PORT_16 2'h1
`define CBIU_SZ_BYTE 2'h0
`define CBIU_SZ_HALF 2'h1
`endif

// >>> hw/cbiu_pkg.sv
// types for the cache and bus interface unit
package cbiu_pkg;
  typedef enum logic [1:0] {
    CBIU_IDLE = 2'b00,
    CBIU_WRITE = 2'b01,
    CBIU_READ = 2'b10,
    CBIU_FILL = 2'b11
  } cbiu_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0] size;
  } cbiu_wb_entry_t;

  typedef struct packed {
    cbiu_state_t st;
    cbiu_wb_entry_t [3:0] wb;
    logic [2:0] wb_cnt;
    logic [1:0] wr_left;
    logic imiss;
    logic dmiss;
    logic [31:0] miss_addr;
    logic [31:0] asm_word;
    logic [3:0][31:0] rb;
    logic [2:0] rb_cnt;
    logic [2:0] rd_total;
    logic [1:0] fill_k;
    logic [1:0][31:0] lb;
    logic [1:0] lb_cnt;
    logic if_valid;
    logic [31:0] if_data;
    logic if_stall;
    logic d_stall;
    logic d_rvalid;
    logic [31:0] bus_addr;
    logic [31:0] bus_wdata;
    logic [3:0] bus_be;
    logic bus_rd;
    logic bus_wr;
    logic bus_quad;
    logic [255:0] ic_val;
    logic [255:0] dc_val;
  } cbiu_regs_t;
endpackage

// >>> hw/cbiu_top.sv
// cache and bus interface unit: caches, write/read buffers, bus sizing
`timescale 1ns/1ns
`default_nettype none
`include "cbiu_cfg.svh"
module cbiu_top import cbiu_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic if_req_in,
  input wire logic [31:0] if_addr_in,
  input wire logic d_req_in,
  input wire logic d_we_in,
  input wire logic [1:0] d_size_in,
  input wire logic [31:0] d_addr_in,
  input wire logic [31:0] d_wdata_in,
  input wire logic d_rready_in,
  input wire logic [1:0] ic_mode_in,
  input wire logic [3:0] ic_lock_in,
  input wire logic [1:0] dc_mode_in,
  input wire logic [3:0] dc_lock_in,
  input wire logic [1:0] bus_width_in,
  input wire logic bus_ack_in,
  input wire logic [31:0] bus_rdata_in,
  output logic if_valid_out,
  output logic [31:0] if_data_out,
  output logic if_stall_out,
  output logic d_stall_out,
  output logic d_rvalid_out,
  output logic [31:0] d_rdata_out,
  output logic [31:0] bus_addr_out,
  output logic [31:0] bus_wdata_out,
  output logic [3:0] bus_be_out,
  output logic bus_rd_out,
  output logic bus_wr_out,
  output logic bus_quad_out
);
  cbiu_regs_t q, d;

  logic [31:0] ic_data [`CBIU_IC_WORDS];
  logic [27:0] ic_tag [`CBIU_IC_LINES];
  logic [31:0] dc_data [`CBIU_DC_LINES];
  logic [29:0] dc_tag [`CBIU_DC_LINES];

  logic ic_we, ic_tag_we, dc_we, dc_tag_we;
  logic [9:0] ic_wi;
  logic [7:0] ic_ti, dc_wi, ic_li, dc_li, f_ii, f_di;
  logic [31:0] ic_wd, dc_wd, fill_word, merged, rd_piece, nxt_addr;
  logic [27:0] ic_wt;
  logic [29:0] dc_wt;
  logic ic_hit, dc_hit;
  logic [3:0] st_be;
  logic [2:0] pw, sz;

  // quarter or half partition picks top index bits
  function automatic logic [7:0] ic_idx(input logic [31:0] a,
                                        input logic [1:0] m);
    if (m == `CBIU_MODE_QUARTER) begin
      return {a[31:30], a[9:4]};
    end else if (m == `CBIU_MODE_HALF) begin
      return {a[31], a[10:4]};
    end else begin
      return a[11:4];
    end
  endfunction

  function automatic logic [7:0] dc_idx(input logic [31:0] a,
                                        input logic [1:0] m);
    if (m == `CBIU_MODE_QUARTER) begin
      return {a[31:30], a[7:2]};
    end else if (m == `CBIU_MODE_HALF) begin
      return {a[31], a[8:2]};
    end else begin
      return a[9:2];
    end
  endfunction

  function automatic logic [2:0] bytes_of(input logic [1:0] s);
    if (s == `CBIU_SZ_BYTE) begin
      return 3'h1;
    end else if (s == `CBIU_SZ_HALF) begin
      return 3'h2;
    end else begin
      return 3'h4;
    end
  endfunction

  function automatic logic [3:0] mask_of(input logic [2:0] n);
    if (n == 3'h1) begin
      return 4'h1;
    end else if (n == 3'h2) begin
      return 4'h3;
    end else begin
      return 4'hf;
    end
  endfunction

  // narrow ports carry their bytes on the low lanes
  function automatic logic [31:0] lane_out(input logic [31:0] v,
                                           input logic [1:0] a,
                                           input logic [2:0] w);
    if (w == 3'h4) begin
      return v;
    end else begin
      return v >> {a, 3'b000};
    end
  endfunction

  always_comb begin
    pw = bytes_of(bus_width_in == `CBIU_PORT_8 ? `CBIU_SZ_BYTE :
                  bus_width_in == `CBIU_PORT_16 ? `CBIU_SZ_HALF : 2'h2);
    sz = bytes_of(d_size_in);
    // lookups use physical address bits only
    ic_li = ic_idx(if_addr_in, ic_mode_in);
    dc_li = dc_idx(d_addr_in, dc_mode_in);
    // full tags cover whole address space
    ic_hit = q.ic_val[ic_li] &&
             ic_tag[ic_li] == if_addr_in[31:`CBIU_LINE_LSB];
    dc_hit = q.dc_val[dc_li] &&
             dc_tag[dc_li] == d_addr_in[31:`CBIU_WORD_LSB];
    st_be = mask_of(sz) << d_addr_in[1:0];
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = st_be[i] ? d_wdata_in[i*8 +: 8]
                                  : dc_data[dc_li][i*8 +: 8];
    end
    f_ii = ic_idx(q.miss_addr, ic_mode_in);
    f_di = dc_idx(q.miss_addr, dc_mode_in);
    fill_word = q.rb[q.fill_k];
    rd_piece = pw == 3'h1 ? {24'h00_0000, bus_rdata_in[7:0]} :
               pw == 3'h2 ? {16'h0000, bus_rdata_in[15:0]} :
               bus_rdata_in;
    nxt_addr = q.bus_addr + {29'h0000_0000, pw};
    ic_we = 1'b0;
    ic_tag_we = 1'b0;
    dc_we = 1'b0;
    dc_tag_we = 1'b0;
    ic_wi = {f_ii, q.fill_k};
    ic_ti = f_ii;
    ic_wd = fill_word;
    ic_wt = q.miss_addr[31:`CBIU_LINE_LSB];
    dc_wi = f_di;
    dc_wd = fill_word;
    dc_wt = q.miss_addr[31:`CBIU_WORD_LSB];

    d = q;
    d.if_valid = 1'b0;
    if (q.lb_cnt != 2'h0 && d_rready_in) begin
      d.lb[0] = q.lb[1];
      d.lb_cnt = q.lb_cnt - 2'h1;
    end

    case (q.st)
      CBIU_IDLE: begin
        // bus used only for misses and writes
        if ((q.imiss || q.dmiss) && q.wb_cnt == 3'h0) begin
          // quad read for fetch, single for load
          d.st = CBIU_READ;
          d.bus_rd = 1'b1;
          d.bus_quad = q.imiss;
          d.bus_be = mask_of(pw);
          d.bus_addr = q.imiss ?
            {q.miss_addr[31:`CBIU_LINE_LSB], 4'h0} :
            {q.miss_addr[31:`CBIU_WORD_LSB], 2'h0};
          d.rd_total = q.imiss ? `CBIU_QUAD_WORDS : 3'h1;
          d.rb_cnt = 3'h0;
          d.asm_word = 32'h0000_0000;
        end else if (q.wb_cnt != 3'h0) begin
          d.st = CBIU_WRITE;
          d.bus_wr = 1'b1;
          d.bus_addr = q.wb[0].addr;
          d.bus_wdata = lane_out(q.wb[0].data, q.wb[0].addr[1:0], pw);
          if (bytes_of(q.wb[0].size) > pw) begin
            d.bus_be = mask_of(pw);
            d.wr_left = 2'(bytes_of(q.wb[0].size) / pw - 3'h1);
          end else begin
            d.bus_be = pw == 3'h4 ?
              mask_of(bytes_of(q.wb[0].size)) << q.wb[0].addr[1:0] :
              mask_of(bytes_of(q.wb[0].size));
            d.wr_left = 2'h0;
          end
        end
      end
      CBIU_WRITE: begin
        if (bus_ack_in) begin
          if (q.wr_left == 2'h0) begin
            d.bus_wr = 1'b0;
            d.st = CBIU_IDLE;
            for (int i = 0; i < `CBIU_WB_DEPTH - 1; i++) begin
              d.wb[i] = q.wb[i+1];
            end
            d.wb_cnt = q.wb_cnt - 3'h1;
          end else begin
            d.wr_left = q.wr_left - 2'h1;
            d.bus_addr = nxt_addr;
            d.bus_wdata = lane_out(q.wb[0].data, nxt_addr[1:0], pw);
          end
        end
      end
      CBIU_READ: begin
        if (bus_ack_in) begin
          // pack narrow beats into a word
          d.asm_word = q.asm_word | (rd_piece << {q.bus_addr[1:0], 3'b000});
          d.bus_addr = nxt_addr;
          if (nxt_addr[1:0] == 2'h0) begin
            // queue words in the read buffer
            d.rb[q.rb_cnt[1:0]] = d.asm_word;
            d.rb_cnt = q.rb_cnt + 3'h1;
            d.asm_word = 32'h0000_0000;
            if (q.rb_cnt + 3'h1 == q.rd_total) begin
              d.bus_rd = 1'b0;
              d.bus_quad = 1'b0;
              d.st = CBIU_FILL;
              d.fill_k = 2'h0;
            end
          end
        end
      end
      CBIU_FILL: begin
        // burst fill, one word per clock
        if (q.imiss) begin
          ic_we = !ic_lock_in[f_ii[7:6]];
          if (q.fill_k == q.miss_addr[3:2]) begin
            d.if_valid = 1'b1;
            d.if_data = fill_word;
          end
          if ({1'b0, q.fill_k} == q.rb_cnt - 3'h1) begin
            ic_tag_we = ic_we;
            d.ic_val[f_ii] = ic_we | q.ic_val[f_ii];
            d.imiss = 1'b0;
            d.st = CBIU_IDLE;
          end
        end else begin
          // locked partition is not refilled; store hits still update it
          dc_we = !dc_lock_in[f_di[7:6]];
          dc_tag_we = dc_we;
          d.dc_val[f_di] = dc_we | q.dc_val[f_di];
          d.lb[d.lb_cnt[0]] = fill_word;
          d.lb_cnt = d.lb_cnt + 2'h1;
          d.dmiss = 1'b0;
          d.st = CBIU_IDLE;
        end
        d.fill_k = q.fill_k + 2'h1;
      end
      default: d.st = CBIU_IDLE;
    endcase

    // fetch port served independently each clock that if_stall is low
    if (if_req_in && !q.if_stall) begin
      if (ic_hit) begin
        d.if_valid = 1'b1;
        d.if_data = ic_data[{ic_li, if_addr_in[3:2]}];
      end else begin
        d.imiss = 1'b1;
        d.miss_addr = if_addr_in;
      end
    end
    if (d_req_in && !q.d_stall) begin
      if (d_we_in) begin
        // one store enters the fifo per clock
        d.wb[d.wb_cnt[1:0]] = '{addr: d_addr_in, data: d_wdata_in,
                                size: d_size_in};
        d.wb_cnt = d.wb_cnt + 3'h1;
        // update on hit, never allocate on miss
        if (dc_hit) begin
          dc_we = 1'b1;
          dc_wi = dc_li;
          dc_wd = merged;
        end
      end else if (dc_hit) begin
        d.lb[d.lb_cnt[0]] = dc_data[dc_li];
        d.lb_cnt = d.lb_cnt + 2'h1;
      end else begin
        d.dmiss = 1'b1;
        d.miss_addr = d_addr_in;
      end
    end
    d.if_stall = d.imiss;
    // stall stores while write buffer full
    d.d_stall = d.wb_cnt == 3'(`CBIU_WB_DEPTH) || d.dmiss ||
                d.lb_cnt == 2'h2;
    // flag kept in a flop so the output has no logic behind it
    d.d_rvalid = d.lb_cnt != 2'h0;
  end

  // icache and dcache misses can overlap but share one miss_addr, which a data miss overwrites
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
    if (ic_we) begin
      ic_data[ic_wi] <= ic_wd;
    end
    if (ic_tag_we) begin
      ic_tag[ic_ti] <= ic_wt;
    end
    if (dc_we) begin
      dc_data[dc_wi] <= dc_wd;
    end
    if (dc_tag_we) begin
      dc_tag[dc_wi] <= dc_wt;
    end
  end

  assign bus_addr_out = q.bus_addr;
  assign bus_wdata_out = q.bus_wdata;
  assign bus_be_out = q.bus_be;
  assign bus_rd_out = q.bus_rd;
  assign bus_wr_out = q.bus_wr;
  assign bus_quad_out = q.bus_quad;
  assign if_valid_out = q.if_valid;
  assign if_data_out = q.if_data;
  assign if_stall_out = q.if_stall;
  assign d_stall_out = q.d_stall;
  assign d_rvalid_out = q.d_rvalid;
  assign d_rdata_out = q.lb[0];
endmodule
`default_nettype wire

// >>> tb/cbiu_props.sv
// port assertions for the cache and bus unit
`timescale 1ns/1ns
`default_nettype none
module cbiu_props (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic if_req_in,
  input wire logic [1:0] bus_width_in,
  input wire logic bus_ack_in,
  input wire logic if_valid_out,
  input wire logic if_stall_out,
  input wire logic [31:0] bus_addr_out,
  input wire logic [3:0] bus_be_out,
  input wire logic bus_rd_out,
  input wire logic bus_wr_out,
  input wire logic bus_quad_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // beats acked in the running quad read
  logic [4:0] qn_q;
  logic [4:0] qexp;
  assign qexp = bus_width_in[1] ? 5'h04 : (bus_width_in[0] ? 5'h08 : 5'h10);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !bus_quad_out) begin
      qn_q <= 5'h00;
    end else if (bus_ack_in) begin
      qn_q <= qn_q + 5'h01;
    end
  end
  a_quad_is_read: assert property (bus_quad_out |-> bus_rd_out)
    else $error("quad without read");
  a_quad_for_fetch: assert property (bus_quad_out |-> if_stall_out)
    else $error("quad without fetch miss");
  a_bus_one_dir: assert property (!(bus_rd_out && bus_wr_out))
    else $error("read and write together");
  a_write_held: assert property (bus_wr_out && !bus_ack_in |=>
    bus_wr_out && $stable(bus_addr_out)) else $error("write not held");
  a_read_held: assert property (bus_rd_out && !bus_ack_in |=>
    bus_rd_out && $stable(bus_addr_out)) else $error("read not held");
  a_fetch_answer: assert property (if_req_in && !if_stall_out |=>
    if_valid_out || if_stall_out) else $error("fetch not answered");
  a_narrow_lanes: assert property (bus_wr_out && !bus_width_in[1] |->
    bus_be_out == (bus_width_in[0] ? 4'h3 : 4'h1)) else $error("bad lanes");
  a_quad_beats: assert property ($fell(bus_quad_out) |-> qn_q == qexp)
    else $error("wrong quad beat count");
  cover property ($fell(bus_quad_out));
  cover property (bus_wr_out && bus_ack_in);
  cover property (bus_rd_out && !bus_quad_out && bus_ack_in);
endmodule
bind cbiu_top cbiu_props i_cbiu_props (.sys_clk_in, .rst_in, .if_req_in,
  .bus_width_in, .bus_ack_in, .if_valid_out, .if_stall_out, .bus_addr_out,
  .bus_be_out, .bus_rd_out, .bus_wr_out, .bus_quad_out);
`default_nettype wire

// >>> tb/cbiu_mem_model.sv
// memory model on the far side of the bus
`timescale 1ns/1ns
`default_nettype none
module cbiu_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] wait_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic ack_out,
  output logic [31:0] rdata_out,
  output logic [7:0] wr_cnt_out,
  output logic [31:0] wr_addr_out,
  output logic [31:0] wr_data_out
);
  logic [3:0] cnt_q;
  logic [31:0] last_q;
  logic [31:0] word;
  assign ack_out = (rd_in || wr_in) && cnt_q == wait_in;
  // writes logged, not stored: misses show the pattern
  assign word = {addr_in[15:2], 2'h0, ~addr_in[15:2], 2'h0};
  assign rdata_out = (ack_out && rd_in) ? word >> {addr_in[1:0], 3'h0} : ~last_q;
  always_ff @(posedge clk_in) begin
    last_q <= rdata_out;
    if (rst_in || !(rd_in || wr_in) || ack_out) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
    if (rst_in) begin
      wr_cnt_out <= 8'h00;
    end else if (ack_out && wr_in) begin
      wr_cnt_out <= wr_cnt_out + 8'h01;
      wr_addr_out <= addr_in;
      wr_data_out <= wdata_in;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the cache and bus unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic if_req_in = 1'b0;
  logic d_req_in = 1'b0;
  logic d_we_in = 1'b0;
  logic d_rready_in = 1'b0;
  logic [1:0] bus_width_in = 2'h2;
  logic [3:0] wt = 4'h0;
  logic [1:0] d_size_in = 2'h2;
  logic [1:0] ic_mode_in = 2'h0;
  logic [1:0] dc_mode_in = 2'h0;
  logic [3:0] ic_lock_in = 4'h0;
  logic [3:0] dc_lock_in = 4'h0;
  logic [31:0] if_addr_in = 32'h0000_0000;
  logic [31:0] d_addr_in = 32'h0000_0000;
  logic [31:0] d_wdata_in = 32'h0000_0000;
  logic bus_ack_in, if_valid_out, if_stall_out, d_stall_out, d_rvalid_out;
  logic bus_rd_out, bus_wr_out;
  logic [31:0] bus_rdata_in, if_data_out, d_rdata_out, bus_addr_out;
  logic [31:0] bus_wdata_out, wa, wd;
  logic [7:0] wn, n;
  int n_fail = 0;
  int n_compared = 0;
  int lat, stalls;
  always #50 sys_clk_in = ~sys_clk_in;
  cbiu_top i_cbiu_top (.sys_clk_in, .rst_in, .if_req_in, .if_addr_in,
    .d_req_in, .d_we_in, .d_size_in, .d_addr_in, .d_wdata_in,
    .d_rready_in, .ic_mode_in, .ic_lock_in, .dc_mode_in,
    .dc_lock_in, .bus_width_in, .bus_ack_in, .bus_rdata_in,
    .if_valid_out, .if_data_out, .if_stall_out, .d_stall_out, .d_rvalid_out,
    .d_rdata_out, .bus_addr_out, .bus_wdata_out, .bus_be_out(), .bus_rd_out,
    .bus_wr_out, .bus_quad_out());
  cbiu_mem_model i_cbiu_mem_model (.clk_in(sys_clk_in), .rst_in, .wait_in(wt),
    .rd_in(bus_rd_out), .wr_in(bus_wr_out), .addr_in(bus_addr_out),
    .wdata_in(bus_wdata_out), .ack_out(bus_ack_in), .rdata_out(bus_rdata_in),
    .wr_cnt_out(wn), .wr_addr_out(wa), .wr_data_out(wd));
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:2], 2'h0, ~a[15:2], 2'h0};
  endfunction
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", s, e, g);
    end
  endtask
  task automatic fetch(input logic [31:0] a);
    if_addr_in <= a;
    if_req_in <= 1'b1;
    do @(posedge sys_clk_in); while (if_stall_out);
    if_req_in <= 1'b0;
    lat = 0;
    do begin
      @(posedge sys_clk_in);
      lat++;
    end while (!if_valid_out && lat < 400);
    chk("fetch data", if_data_out, pat(a));
  endtask
  task automatic load(input logic [31:0] a, input logic [31:0] e);
    d_addr_in <= a;
    d_we_in <= 1'b0;
    d_req_in <= 1'b1;
    do @(posedge sys_clk_in); while (d_stall_out);
    d_req_in <= 1'b0;
    lat = 0;
    do begin
      @(posedge sys_clk_in);
      lat++;
    end while (!d_rvalid_out && lat < 400);
    chk("load data", d_rdata_out, e);
    d_rready_in <= 1'b1;
    @(posedge sys_clk_in);
    d_rready_in <= 1'b0;
  endtask
  // request stays up; caller lowers it
  task automatic store(input logic [31:0] a, input logic [31:0] w);
    d_addr_in <= a;
    d_wdata_in <= w;
    d_we_in <= 1'b1;
    d_req_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      stalls += d_stall_out;
    end while (d_stall_out);
  endtask
  task automatic wait_wr(input logic [7:0] c);
    for (int i = 0; i < 900 && wn !== c; i++) @(posedge sys_clk_in);
  endtask
  task automatic t_fetch;
    fetch(32'h0000_0108);
    fetch(32'h0000_010c);
    chk("hit latency", lat, 1);
    fetch(32'h0000_1100);
    fetch(32'h0000_0100);
    chk("conflict miss", lat > 1, 1);
    fetch(32'hf000_0200);
    $display("fetch test done");
  endtask
  task automatic t_data;
    wt <= 4'h1;
    load(32'h0000_0400, pat(32'h0000_0400));
    n = wn;
    store(32'h0000_0400, 32'h1234_5678);
    load(32'h0000_0400, 32'h1234_5678);
    chk("hit latency", lat, 1);
    wait_wr(n + 8'h01);
    chk("memory copy", wd, 32'h1234_5678);
    d_size_in <= 2'h1;
    store(32'h0000_0402, 32'hbeef_0000);
    d_size_in <= 2'h2;
    load(32'h0000_0400, 32'hbeef_5678);
    wait_wr(n + 8'h02);
    chk("half addr", wa, 32'h0000_0402);
    chk("half data", wd, 32'hbeef_0000);
    store(32'h0000_0484, 32'h0bad_0bad);
    load(32'h0000_0484, pat(32'h0000_0484));
    $display("data test done");
  endtask
  task automatic t_bus;
    wt <= 4'h2;
    bus_width_in <= 2'h1;
    fetch(32'h0000_0208);
    n = wn;
    store(32'h0000_0500, 32'haabb_ccdd);
    d_req_in <= 1'b0;
    wait_wr(n + 8'h02);
    chk("piece addr", wa, 32'h0000_0502);
    chk("piece data", wd[15:0], 16'haabb);
    bus_width_in <= 2'h0;
    load(32'h0000_0480, pat(32'h0000_0480));
    bus_width_in <= 2'h2;
    wt <= 4'h6;
    n = wn;
    stalls = 0;
    for (int k = 0; k < 6; k++) store(32'h0000_0600 + 32'(4 * k), 32'(k));
    d_req_in <= 1'b0;
    chk("store stall", stalls > 0, 1);
    wait_wr(n + 8'h06);
    chk("last addr", wa, 32'h0000_0614);
    chk("last data", wd, 32'h0000_0005);
    $display("bus test done");
  endtask
  // quarter 0 locked in both caches, quarter 1 still fills
  task automatic t_lock;
    wt <= 4'h0;
    ic_mode_in <= 2'h2;
    ic_lock_in <= 4'h1;
    dc_mode_in <= 2'h2;
    dc_lock_in <= 4'h1;
    fetch(32'h0000_0300);
    fetch(32'h0000_0300);
    chk("locked fetch", lat > 1, 1);
    fetch(32'h4000_0300);
    fetch(32'h4000_0300);
    chk("open fetch", lat, 1);
    load(32'h0000_0700, pat(32'h0000_0700));
    load(32'h0000_0700, pat(32'h0000_0700));
    chk("locked load", lat > 1, 1);
    load(32'h4000_0704, pat(32'h4000_0704));
    load(32'h4000_0704, pat(32'h4000_0704));
    chk("open load", lat, 1);
    $display("lock test done");
  endtask
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_fetch();
    t_data();
    t_bus();
    t_lock();
    stop_test();
  end
  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
